// >>> rtl/cbs_consts.vh
// Contract
// - Writing one clears a latched event bit
// - Card parity error sets bit 15
// - Card system error line sets bit 14
// - Bridge never drives the system error line
// - Master abort on own cycle sets 13
// - Target abort on own cycle sets 12
// - Bridge signalling target abort sets 11
// - Bits 10..9 read fixed 01b timing code
// - Bit 8 needs CPERR, mastership, enable
// - Bit 7 always reads zero
// - Bit 6 always reads zero
// - Bit 5 always reads zero
// - Bits 4..0 always read zero
// - Status reads 0200h after reset
// - Bus numbers programmed, used for forwarding
`ifndef CBS_CONSTS_VH
`define CBS_CONSTS_VH

// ============================================================
// Configuration offsets (byte addresses; the DW ones and CBS_OFS_UPSTREAM are dword aligned)
`define CBS_DW_STATUS        8'h14
`define CBS_DW_BUSNUM        8'h18
`define CBS_OFS_STATUS       8'h16
`define CBS_OFS_UPSTREAM     8'h18
`define CBS_OFS_CARDBUS      8'h19
`define CBS_OFS_SUBORD       8'h1a
`define CBS_DW_MASK          8'hfc

// ============================================================
// Status field positions
`define CBS_BIT_PARITY       15
`define CBS_BIT_SERR         14
`define CBS_BIT_MABORT       13
`define CBS_BIT_TA_RCVD      12
`define CBS_BIT_TA_SIG       11
`define CBS_BIT_DPAR         8
`define CBS_TIMING_HI        10
`define CBS_TIMING_LO        9
`define CBS_BIT_B2B          7
`define CBS_BIT_UDF          6
`define CBS_BIT_66M          5

// ============================================================
// Fixed values and reset values
`define CBS_TIMING_CODE      2'h1
`define CBS_STATUS_RESET     16'h0200
`define CBS_BUS_RESET        8'h00
`define CBS_ZERO32           32'h00000000
`define CBS_ZERO16           16'h0000
`define CBS_ZERO8            8'h00
`define CBS_PIN_IDLE         1'h1

`endif

// >>> rtl/cbs_pin_sync.v
`default_nettype none

// ============================================================
// Pin synchroniser: three flops, level accepted once stages two and three agree
module cbs_pin_sync #(
    parameter IDLE = 1'b1
) (
    input  wire clock,
    input  wire resetn,
    input  wire ce,
    input  wire pin,
    output reg  level
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge clock) begin
        if (!resetn) begin
            stage1 <= IDLE;
            stage2 <= IDLE;
            stage3 <= IDLE;
            level  <= IDLE;
        end else if (ce) begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            // Stage one feeds stage two only; the filter looks at two and three
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

// >>> rtl/cbs_top.v
`include "cbs_consts.vh"
`default_nettype none

// ============================================================
// Card-side error status and bus number registers of the bridge
module cbs_top (
    input  wire        clock,
    input  wire        resetn,
    input  wire        ce,
    // Configuration access
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    output reg         cfg_rvalid,
    // Card-side pins
    input  wire        card_serr_n_in,
    output reg         card_serr_n_out,
    output reg         card_serr_n_oe,
    input  wire        card_perr_n_in,
    // Card-side events from the bridge's own bus logic
    input  wire        card_parity_event,
    input  wire        master_abort_event,
    input  wire        target_abort_rcvd_event,
    input  wire        target_abort_sig_event,
    input  wire        bridge_is_master,
    input  wire        parity_response_enable,
    // Configuration forwarding decode
    input  wire        fwd_req,
    input  wire [7:0]  fwd_bus,
    output reg         fwd_valid,
    output reg         fwd_type0,
    output reg         fwd_type1,
    output reg         fwd_none,
    // Status copies for the rest of the bridge
    output reg  [15:0] status_view,
    output reg  [7:0]  upstream_bus_view,
    output reg  [7:0]  card_bus_view,
    output reg  [7:0]  subord_bus_view
);

    // ============================================================
    // Register state
    reg        card_parity_detected;
    reg        card_system_error_seen;
    reg        card_master_abort_received;
    reg        card_target_abort_received;
    reg        card_target_abort_signaled;
    reg        card_data_parity_reported;
    reg [7:0]  upstream_bus_index;
    reg [7:0]  card_side_bus_index;
    reg [7:0]  subord_bus_index;

    // Event flops start from the reset word so the fixed code and the flags agree
    localparam [15:0] STATUS_INIT = `CBS_STATUS_RESET;

    // ============================================================
    // Pin synchronisers
    // Both error pins idle high behind pull-ups, so the syncs reset to that level
    wire serr_level_n;
    wire perr_level_n;

    cbs_pin_sync #(
        .IDLE (`CBS_PIN_IDLE)
    ) u_serr_sync (
        .clock  (clock),
        .resetn (resetn),
        .ce     (ce),
        .pin    (card_serr_n_in),
        .level  (serr_level_n)
    );

    cbs_pin_sync #(
        .IDLE (`CBS_PIN_IDLE)
    ) u_perr_sync (
        .clock  (clock),
        .resetn (resetn),
        .ce     (ce),
        .pin    (card_perr_n_in),
        .level  (perr_level_n)
    );

    // ============================================================
    // Access decode
    wire        hit_status_dw;
    wire        hit_busnum_dw;
    wire        wr_status;
    wire        wr_busnum;
    reg  [15:0] clear_mask;

    assign hit_status_dw = ((cfg_addr & `CBS_DW_MASK) == `CBS_DW_STATUS);
    assign hit_busnum_dw = ((cfg_addr & `CBS_DW_MASK) == `CBS_DW_BUSNUM);
    assign wr_status     = cfg_wr && hit_status_dw;
    assign wr_busnum     = cfg_wr && hit_busnum_dw;

    // Status occupies the upper half of its dword; lanes two and three
    // Lanes zero and one belong to other registers and never touch these bits
    always @* begin
        clear_mask = `CBS_ZERO16;
        if (wr_status && cfg_be[3]) begin
            clear_mask[15:8] = cfg_wdata[31:24];
        end
        if (wr_status && cfg_be[2]) begin
            clear_mask[7:0] = cfg_wdata[23:16];
        end
    end

    // ============================================================
    // Event sources
    wire serr_event;
    wire dpar_event;

    // A level held low by the card keeps setting the bit, so a clear
    // during a still-asserted error does not stick; that is intended
    assign serr_event = !serr_level_n;
    assign dpar_event = !perr_level_n && bridge_is_master
                        && parity_response_enable;

    // ============================================================
    // Next values of latched bits: set beats clear in the same cycle
    wire next_parity;
    wire next_serr;
    wire next_mabort;
    wire next_ta_rcvd;
    wire next_ta_sig;
    wire next_dpar;

    assign next_parity  = card_parity_event ||
                          (card_parity_detected &&
                           !clear_mask[`CBS_BIT_PARITY]);
    assign next_serr    = serr_event ||
                          (card_system_error_seen &&
                           !clear_mask[`CBS_BIT_SERR]);
    assign next_mabort  = master_abort_event ||
                          (card_master_abort_received &&
                           !clear_mask[`CBS_BIT_MABORT]);
    assign next_ta_rcvd = target_abort_rcvd_event ||
                          (card_target_abort_received &&
                           !clear_mask[`CBS_BIT_TA_RCVD]);
    assign next_ta_sig  = target_abort_sig_event ||
                          (card_target_abort_signaled &&
                           !clear_mask[`CBS_BIT_TA_SIG]);
    assign next_dpar    = dpar_event ||
                          (card_data_parity_reported &&
                           !clear_mask[`CBS_BIT_DPAR]);

    always @(posedge clock) begin
        if (!resetn) begin
            card_parity_detected       <= STATUS_INIT[`CBS_BIT_PARITY];
            card_system_error_seen     <= STATUS_INIT[`CBS_BIT_SERR];
            card_master_abort_received <= STATUS_INIT[`CBS_BIT_MABORT];
            card_target_abort_received <= STATUS_INIT[`CBS_BIT_TA_RCVD];
            card_target_abort_signaled <= STATUS_INIT[`CBS_BIT_TA_SIG];
            card_data_parity_reported  <= STATUS_INIT[`CBS_BIT_DPAR];
        end else if (ce) begin
            card_parity_detected       <= next_parity;
            card_system_error_seen     <= next_serr;
            card_master_abort_received <= next_mabort;
            card_target_abort_received <= next_ta_rcvd;
            card_target_abort_signaled <= next_ta_sig;
            card_data_parity_reported  <= next_dpar;
        end
    end

    // ============================================================
    // Assembled status word; hardwired fields are constants here
    reg [15:0] next_status;

    always @* begin
        next_status                    = `CBS_ZERO16;
        next_status[`CBS_BIT_PARITY]   = next_parity;
        next_status[`CBS_BIT_SERR]     = next_serr;
        next_status[`CBS_BIT_MABORT]   = next_mabort;
        next_status[`CBS_BIT_TA_RCVD]  = next_ta_rcvd;
        next_status[`CBS_BIT_TA_SIG]   = next_ta_sig;
        next_status[`CBS_TIMING_HI:`CBS_TIMING_LO] = `CBS_TIMING_CODE;
        next_status[`CBS_BIT_DPAR]     = next_dpar;
        next_status[`CBS_BIT_B2B]      = 1'b0;
        next_status[`CBS_BIT_UDF]      = 1'b0;
        next_status[`CBS_BIT_66M]      = 1'b0;
    end

    reg  [15:0] cur_status;

    // Reads see the flops as they stand; a same-cycle event shows on the next read
    always @* begin
        cur_status                    = `CBS_ZERO16;
        cur_status[`CBS_BIT_PARITY]   = card_parity_detected;
        cur_status[`CBS_BIT_SERR]     = card_system_error_seen;
        cur_status[`CBS_BIT_MABORT]   = card_master_abort_received;
        cur_status[`CBS_BIT_TA_RCVD]  = card_target_abort_received;
        cur_status[`CBS_BIT_TA_SIG]   = card_target_abort_signaled;
        cur_status[`CBS_TIMING_HI:`CBS_TIMING_LO] = `CBS_TIMING_CODE;
        cur_status[`CBS_BIT_DPAR]     = card_data_parity_reported;
        cur_status[`CBS_BIT_B2B]      = 1'b0;
        cur_status[`CBS_BIT_UDF]      = 1'b0;
        cur_status[`CBS_BIT_66M]      = 1'b0;
    end

    // ============================================================
    // Bus number registers, written per byte lane
    reg  [7:0] next_upstream;
    reg  [7:0] next_card_bus;
    reg  [7:0] next_subord;

    // Subordinate number lives here too because the forwarding decode needs it
    always @* begin
        next_upstream = upstream_bus_index;
        next_card_bus = card_side_bus_index;
        next_subord   = subord_bus_index;
        if (wr_busnum && cfg_be[0]) begin
            next_upstream = cfg_wdata[7:0];
        end
        if (wr_busnum && cfg_be[1]) begin
            next_card_bus = cfg_wdata[15:8];
        end
        if (wr_busnum && cfg_be[2]) begin
            next_subord = cfg_wdata[23:16];
        end
    end

    always @(posedge clock) begin
        if (!resetn) begin
            upstream_bus_index  <= `CBS_BUS_RESET;
            card_side_bus_index <= `CBS_BUS_RESET;
            subord_bus_index    <= `CBS_BUS_RESET;
        end else if (ce) begin
            upstream_bus_index  <= next_upstream;
            card_side_bus_index <= next_card_bus;
            subord_bus_index    <= next_subord;
        end
    end

    // ============================================================
    // Read path: data registered, valid one cycle after the request
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = `CBS_ZERO32;
        case (cfg_addr & `CBS_DW_MASK)
            `CBS_DW_STATUS: begin
                next_rdata[31:16] = cur_status;
            end
            `CBS_DW_BUSNUM: begin
                // Latency timer byte belongs to other logic and reads zero here
                next_rdata = {`CBS_ZERO8, subord_bus_index,
                              card_side_bus_index, upstream_bus_index};
            end
            default: begin
                // Unmapped dwords read as zero so probing software sees nothing
                next_rdata = `CBS_ZERO32;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!resetn) begin
            cfg_rdata  <= `CBS_ZERO32;
            cfg_rvalid <= 1'b0;
        end else if (ce) begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // ============================================================
    // Forwarding decode against the programmed bus numbers
    wire is_local;
    wire is_below;

    assign is_local = (fwd_bus == card_side_bus_index);
    assign is_below = (fwd_bus > card_side_bus_index) &&
                      (fwd_bus <= subord_bus_index);

    reg next_type0;
    reg next_type1;
    reg next_none;

    // A zero subordinate number leaves nothing below the card bus, so only type 0 matches
    always @* begin
        next_type0 = 1'b0;
        next_type1 = 1'b0;
        next_none  = 1'b0;
        if (fwd_req) begin
            if (is_local) begin
                next_type0 = 1'b1;
            end else if (is_below) begin
                next_type1 = 1'b1;
            end else begin
                next_none = 1'b1;
            end
        end
    end

    always @(posedge clock) begin
        if (!resetn) begin
            fwd_valid <= 1'b0;
            fwd_type0 <= 1'b0;
            fwd_type1 <= 1'b0;
            fwd_none  <= 1'b0;
        end else if (ce) begin
            fwd_valid <= fwd_req;
            fwd_type0 <= next_type0;
            fwd_type1 <= next_type1;
            fwd_none  <= next_none;
        end
    end

    // ============================================================
    // System error pin: input only, the driver is held off forever
    always @(posedge clock) begin
        if (!resetn) begin
            card_serr_n_out <= `CBS_PIN_IDLE;
            card_serr_n_oe  <= 1'b0;
        end else if (ce) begin
            card_serr_n_out <= `CBS_PIN_IDLE;
            card_serr_n_oe  <= 1'b0;
        end
    end

    // ============================================================
    // Registered views; status view shows the value that the flops take
    always @(posedge clock) begin
        if (!resetn) begin
            status_view       <= `CBS_STATUS_RESET;
            upstream_bus_view <= `CBS_BUS_RESET;
            card_bus_view     <= `CBS_BUS_RESET;
            subord_bus_view   <= `CBS_BUS_RESET;
        end else if (ce) begin
            status_view       <= next_status;
            upstream_bus_view <= next_upstream;
            card_bus_view     <= next_card_bus;
            subord_bus_view   <= next_subord;
        end
    end

endmodule

`default_nettype wire

// >>> verification/cbs_checker.sv
`default_nettype none
// ============================================================
// Port checker for the card-side status block
module cbs_checker (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic        card_serr_n_oe,
    input wire logic        card_parity_event,
    input wire logic        master_abort_event,
    input wire logic        target_abort_rcvd_event,
    input wire logic        target_abort_sig_event,
    input wire logic        bridge_is_master,
    input wire logic        parity_response_enable,
    input wire logic        fwd_valid,
    input wire logic        fwd_type0,
    input wire logic        fwd_type1,
    input wire logic        fwd_none,
    input wire logic [15:0] status_view
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // A write in the gap cycle could clear the bit before the check samples the copy
    sequence quiet;
        ce && !cfg_wr;
    endsequence
    a_never_drives: assert property (!card_serr_n_oe)
        else $error("system error line enabled");
    a_parity_sets: assert property (ce && card_parity_event ##1 quiet |=> status_view[15])
        else $error("parity bit not set");
    a_mabort_sets: assert property (ce && master_abort_event ##1 quiet |=> status_view[13])
        else $error("master abort bit not set");
    a_tarcvd_sets: assert property (ce && target_abort_rcvd_event ##1 quiet |=> status_view[12])
        else $error("target abort received bit not set");
    a_tasig_sets: assert property (ce && target_abort_sig_event ##1 quiet |=> status_view[11])
        else $error("target abort signalled bit not set");
    a_fixed_fields: assert property (status_view[10:9] == 2'h1 && status_view[7:0] == 8'h00)
        else $error("fixed status fields wrong");
    a_dpar_gated: assert property ($rose(status_view[8]) |-> $past(bridge_is_master) && $past(parity_response_enable))
        else $error("data parity bit set without its conditions");
    a_write_clears: assert property (ce && cfg_wr && cfg_addr[7:2] == 6'h05 && cfg_be[3] && cfg_wdata[29]
        && !master_abort_event ##1 ce && !master_abort_event |=> !status_view[13])
        else $error("write one did not clear");
    a_fwd_onehot: assert property (fwd_valid |-> $onehot({fwd_type0, fwd_type1, fwd_none}))
        else $error("forward decode not one-hot");
    c_dpar_set: cover property ($rose(status_view[8]));
    c_serr_set: cover property ($rose(status_view[14]));
    c_fwd_type1: cover property (fwd_valid && fwd_type1);
endmodule
bind cbs_top cbs_checker cbs_checker_inst (.clock, .resetn, .ce, .cfg_wr, .cfg_addr, .cfg_be,
    .cfg_wdata, .card_serr_n_oe, .card_parity_event, .master_abort_event, .target_abort_rcvd_event,
    .target_abort_sig_event, .bridge_is_master, .parity_response_enable, .fwd_valid, .fwd_type0,
    .fwd_type1, .fwd_none, .status_view);
`default_nettype wire

// >>> verification/cbs_card_model.sv
`default_nettype none
// ============================================================
// Card on the secondary bus: pulls its error lines low on request
module cbs_card_model (
    input wire logic  serr_req,
    input wire logic  perr_req,
    input wire logic  bridge_serr_out,
    input wire logic  bridge_serr_oe,
    output var logic  serr_line_n,
    output var logic  perr_line_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines have pull-ups, so a released line reads high, never the old value
    always_comb begin
        serr_line_n = !(serr_req || (bridge_serr_oe && !bridge_serr_out));
        perr_line_n = !perr_req;
    end
endmodule
`default_nettype wire

// >>> verification/cbs_top_tb.sv
`default_nettype none
// ============================================================
// Register-level bench for the card-side status block
module cbs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, resetn = 1'b0, ce = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [7:0]  cfg_addr = 8'h00, fwd_bus = 8'h00;
    logic [3:0]  cfg_be = 4'h0, ev = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, e;
    logic        cfg_rvalid, serr_out, serr_oe, serr_line_n, perr_line_n;
    logic        serr_req = 1'b0, perr_req = 1'b0, bim = 1'b0, pre = 1'b0, fwd_req = 1'b0;
    logic        fwd_valid, fwd_type0, fwd_type1, fwd_none;
    logic [15:0] status_view;
    logic [7:0]  ubv, cbv, sbv;
    int          n_fail = 0, samples_checked = 0, cycles = 0;
    int          bp [4] = '{15, 13, 12, 11};
    logic [7:0]  bl [5] = '{8'h02, 8'h04, 8'h05, 8'h06, 8'h01};
    logic [2:0]  tl [5] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
    initial forever #50 clock = ~clock;
    cbs_top cbs_top_inst (.clock, .resetn, .ce, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata,
        .cfg_rdata, .cfg_rvalid, .card_serr_n_in(serr_line_n), .card_serr_n_out(serr_out),
        .card_serr_n_oe(serr_oe), .card_perr_n_in(perr_line_n), .card_parity_event(ev[0]),
        .master_abort_event(ev[1]), .target_abort_rcvd_event(ev[2]),
        .target_abort_sig_event(ev[3]), .bridge_is_master(bim), .parity_response_enable(pre),
        .fwd_req, .fwd_bus, .fwd_valid, .fwd_type0, .fwd_type1, .fwd_none, .status_view,
        .upstream_bus_view(ubv), .card_bus_view(cbv), .subord_bus_view(sbv));
    cbs_card_model cbs_card_model_inst (.serr_req, .perr_req, .bridge_serr_out(serr_out),
        .bridge_serr_oe(serr_oe), .serr_line_n, .perr_line_n);
    task automatic check(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        @(posedge clock);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= b;
        cfg_wdata <= d;
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask
    task automatic cfg_read(input logic [7:0] a, input logic [31:0] x);
        @(posedge clock);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clock);
        cfg_rd <= 1'b0;
        #1;
        check({31'h0, cfg_rvalid}, 32'h1);
        check(cfg_rdata, x);
    endtask
    task automatic fwd(input logic [7:0] b, input logic [2:0] x);
        @(posedge clock);
        fwd_req <= 1'b1;
        fwd_bus <= b;
        @(posedge clock);
        fwd_req <= 1'b0;
        #1;
        check({28'h0, fwd_valid, fwd_type0, fwd_type1, fwd_none}, {29'h1, x});
    endtask
    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev[i] <= 1'b0;
    endtask
    // Long enough for the pin synchroniser to settle both ways
    task automatic card_pulse(input logic s, input logic p);
        @(posedge clock);
        serr_req <= s;
        perr_req <= p;
        repeat (8) @(posedge clock);
        serr_req <= 1'b0;
        perr_req <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            $display("BAD t=%0t cycles %h limit %h", $time, cycles, 2000);
            close_out();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        cfg_read(8'h14, 32'h02000000);
        check({16'h0, status_view}, 32'h0200);
        cfg_read(8'h18, 32'h0);
        cfg_read(8'h3c, 32'h0);
        $display("test reset done");
        cfg_write(8'h18, 4'hf, 32'hff050201);
        cfg_read(8'h18, 32'h00050201);
        check({8'h0, sbv, cbv, ubv}, 32'h00050201);
        for (int i = 0; i < 5; i++) fwd(bl[i], tl[i]);
        $display("test bus numbers done");
        @(posedge clock);
        ce <= 1'b0;
        pulse(1);
        cfg_write(8'h18, 4'hf, 32'h0);
        @(posedge clock);
        ce <= 1'b1;
        cfg_read(8'h14, 32'h02000000);
        cfg_read(8'h18, 32'h00050201);
        $display("test clock enable done");
        for (int i = 0; i < 4; i++) begin
            e = 32'h02000000 | (32'h1 << (16 + bp[i]));
            pulse(i);
            cfg_read(8'h14, e);
            check({16'h0, status_view}, e >> 16);
            cfg_write(8'h14, 4'hc, ~e);
            cfg_read(8'h14, e);
            cfg_write(8'h14, 4'h3, 32'hffffffff);
            cfg_read(8'h14, e);
            cfg_write(8'h14, 4'hc, e);
            cfg_read(8'h14, 32'h02000000);
        end
        $display("test events done");
        card_pulse(1'b1, 1'b0);
        cfg_read(8'h14, 32'h42000000);
        cfg_write(8'h14, 4'hc, 32'h40000000);
        cfg_read(8'h14, 32'h02000000);
        check({30'h0, serr_oe, serr_out}, 32'h1);
        $display("test system error done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            bim <= i[0];
            pre <= i[1];
            card_pulse(1'b0, 1'b1);
            cfg_read(8'h14, (i == 3) ? 32'h03000000 : 32'h02000000);
            cfg_write(8'h14, 4'hc, 32'h01000000);
        end
        $display("test data parity done");
        pulse(0);
        cfg_read(8'h14, 32'h82000000);
        @(posedge clock);
        resetn <= 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        cfg_read(8'h14, 32'h02000000);
        cfg_read(8'h18, 32'h0);
        check({16'h0, status_view}, 32'h0200);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
